// *** psc_map.svh ***
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH

// ****************************************
// Register indices on the register port
// ****************************************
`define PSC_IDX_CTRL 5'h00
`define PSC_IDX_ADV 5'h04
`define PSC_IDX_SMODE 5'h12
`define PSC_IDX_STRAP 5'h1F

// ****************************************
// Field positions
// ****************************************
`define PSC_CTRL_SRST 15
`define PSC_CTRL_SPD 13
`define PSC_CTRL_ANEN 12
`define PSC_CTRL_PDN 11
`define PSC_CTRL_ISO 10
`define PSC_CTRL_DPX 8
`define PSC_ADV_MSB 8
`define PSC_ADV_LSB 5
`define PSC_SM_MODE_MSB 7
`define PSC_SM_MODE_LSB 5
`define PSC_SM_ADDR_MSB 4

// ****************************************
// Reset values and internal pull levels
// ****************************************
`define PSC_CTRL_RST 4'h0
`define PSC_ADV_RST 4'h0
`define PSC_ADDR_RST 5'h00
`define PSC_STRAP_RST 4'h0
`define PSC_PULL_LVL 4'hE

// ****************************************
// Mode strap codes and loaded bit values
// ****************************************
`define PSC_MODE_10HD 3'h0
`define PSC_MODE_10FD 3'h1
`define PSC_MODE_100HD 3'h2
`define PSC_MODE_100FD 3'h3
`define PSC_MODE_AN100HD 3'h4
`define PSC_MODE_RPT 3'h5
`define PSC_MODE_PDN 3'h6
`define PSC_MODE_ALL 3'h7
`define PSC_CL_10HD 4'h0
`define PSC_CL_10FD 4'h1
`define PSC_CL_100HD 4'h8
`define PSC_CL_100FD 4'h9
`define PSC_CL_AN 4'hC
`define PSC_CL_ALL 4'hD
`define PSC_AL_100HD 4'h4
`define PSC_AL_ALL 4'hF

`endif

// *** psc_pkg.sv ***
package psc_pkg;

  typedef logic [4:0] psc_addr_t;
  typedef logic [15:0] psc_data_t;
  typedef logic [2:0] psc_mode_t;
  typedef logic [3:0] psc_adv_t;

  // Shared receive pins; bit order also gives the pull-level layout.
  typedef struct packed {
    logic crs_dv;
    logic [1:0] rxd;
    logic rx_er;
  } psc_rmii_rx_t;

  typedef struct packed {
    logic address_strap_bit;
    psc_mode_t mode;
  } psc_strap_t;

  // Control bits 13, 12, 10 and 8, in that order.
  typedef struct packed {
    logic spd100;
    logic an_en;
    logic iso;
    logic dpx;
  } psc_ctrl_t;

  typedef struct packed {
    logic repeater;
    logic crs_tx;
    logic power_down;
  } psc_opmode_t;

  typedef struct packed {
    logic we;
    logic re;
    psc_addr_t addr;
    psc_data_t wdata;
  } psc_bus_req_t;

  typedef enum logic [2:0] {
    PSC_PH_RESET = 3'b001,
    PSC_PH_CAPT = 3'b010,
    PSC_PH_RUN = 3'b100
  } psc_phase_t;

endpackage

// *** psc_sync2.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Two-stage synchroniser
// ****************************************
// No reset: the owner keeps its logic in reset until both stages hold
// settled pin levels.
module psc_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk) begin
    meta_r <= d;
    q <= meta_r;
  end

endmodule

`default_nettype wire

// *** psc_loader.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "psc_map.svh"

// Contract
// - Capture all straps at power-on and pin reset, use them as defaults.
// - Each strap pin has an internal pull to a defined level.
// - Address strap bit stored at reset end; defaults to zero.
// - Answer a management frame only when its address matches ours.
// - Stored management address seeds the transmit scrambler.
// - Strap gives address 0 or 1; software may write larger ones.
// - Address strap shares the receive-error pin, driven after reset.
// - Pin reset release loads control and advertisement bits from mode.
// - Soft reset keeps register values and does not reload straps.
// - Software may change the strapped mode through registers.
// - Mode 000: 10 Mb/s half duplex, control 0000, advertisement kept.
// - Mode 001: 10 Mb/s full duplex, control 0001, advertisement kept.
// - Mode 010: 100 Mb/s half duplex, control 1000, carrier on both.
// - Mode 011: 100 Mb/s full duplex, control 1001, carrier on receive.
// - Mode 100: negotiate 100 half only, control 1100, advert 0100.
// - Mode 101: repeater, control 1100, advert 0100, carrier on receive.
// - Mode 110: powered down until mode field changed and soft reset.
// - Mode 111: negotiate all abilities, advertisement 1111.
// - Mode bits come from receive data 0, data 1, carrier-valid pins.
module psc_loader (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pin_reset_n,
  input wire psc_pkg::psc_rmii_rx_t pad_i,
  output psc_pkg::psc_rmii_rx_t pad_o_r,
  output psc_pkg::psc_rmii_rx_t pad_oe_r,
  output psc_pkg::psc_rmii_rx_t pad_pu_r,
  input wire psc_pkg::psc_rmii_rx_t core_rx,
  input wire psc_pkg::psc_bus_req_t bus_req,
  output psc_pkg::psc_data_t bus_rdata_r,
  input wire logic frm_valid,
  input wire psc_pkg::psc_addr_t frm_addr,
  output logic frm_match_r,
  output psc_pkg::psc_addr_t scr_seed_r,
  output psc_pkg::psc_addr_t station_address_field_r,
  output psc_pkg::psc_ctrl_t ctrl_r,
  output psc_pkg::psc_adv_t adv_r,
  output psc_pkg::psc_opmode_t opmode_r,
  output logic soft_rst_r,
  output psc_pkg::psc_strap_t strap_r
);

  import psc_pkg::*;

  // ****************************************
  // Pin synchronisers and hardware reset
  // ****************************************
  psc_rmii_rx_t pad_s;
  logic pin_rst_n_s;
  logic hw_rst;
  psc_phase_t phase_r;
  logic capture;

  psc_sync2 #(.W(4)) u_pad_sync (
    .clk(clk),
    .d(pad_i),
    .q(pad_s)
  );

  psc_sync2 #(.W(1)) u_rst_sync (
    .clk(clk),
    .d(pin_reset_n),
    .q(pin_rst_n_s)
  );

  // Power-on and pin reset act alike; soft reset is not part of this.
  assign hw_rst = sys_rst | ~pin_rst_n_s;

  // The straps are caught in the second cycle after reset release, while
  // the shared pins are still undriven by us; the board must hold them
  // steady until then.
  always_ff @(posedge clk) begin
    if (hw_rst) begin
      phase_r <= PSC_PH_RESET;
    end else begin
      case (phase_r)
        PSC_PH_RESET: phase_r <= PSC_PH_CAPT;
        PSC_PH_CAPT: phase_r <= PSC_PH_RUN;
        PSC_PH_RUN: phase_r <= PSC_PH_RUN;
        default: phase_r <= PSC_PH_RESET;
      endcase
    end
  end

  assign capture = (phase_r == PSC_PH_CAPT);

  // ****************************************
  // Register port decode
  // ****************************************
  logic wr_ctrl;
  logic wr_adv;
  logic wr_smode;
  logic soft_req;

  assign wr_ctrl = bus_req.we && (bus_req.addr == `PSC_IDX_CTRL);
  assign wr_adv = bus_req.we && (bus_req.addr == `PSC_IDX_ADV);
  assign wr_smode = bus_req.we && (bus_req.addr == `PSC_IDX_SMODE);
  assign soft_req = wr_ctrl && bus_req.wdata[`PSC_CTRL_SRST];

  // ****************************************
  // Mode decode tables
  // ****************************************
  function automatic psc_ctrl_t ctrl_of(input psc_mode_t m,
                                        input psc_ctrl_t cur);
    case (m)
      `PSC_MODE_10HD: ctrl_of = `PSC_CL_10HD;
      `PSC_MODE_10FD: ctrl_of = `PSC_CL_10FD;
      `PSC_MODE_100HD: ctrl_of = `PSC_CL_100HD;
      `PSC_MODE_100FD: ctrl_of = `PSC_CL_100FD;
      `PSC_MODE_AN100HD: ctrl_of = `PSC_CL_AN;
      `PSC_MODE_RPT: ctrl_of = `PSC_CL_AN;
      `PSC_MODE_ALL: ctrl_of = `PSC_CL_ALL;
      default: ctrl_of = cur;
    endcase
  endfunction

  function automatic psc_adv_t adv_of(input psc_mode_t m,
                                      input psc_adv_t cur);
    case (m)
      `PSC_MODE_AN100HD: adv_of = `PSC_AL_100HD;
      `PSC_MODE_RPT: adv_of = `PSC_AL_100HD;
      `PSC_MODE_ALL: adv_of = `PSC_AL_ALL;
      default: adv_of = cur;
    endcase
  endfunction

  // Carrier sense on transmit only in modes 010 and 100; repeater is mode 101.
  function automatic psc_opmode_t op_of(input psc_mode_t m);
    op_of.repeater = (m == `PSC_MODE_RPT);
    op_of.crs_tx = (m == `PSC_MODE_100HD) ||
                   (m == `PSC_MODE_AN100HD);
    op_of.power_down = (m == `PSC_MODE_PDN);
  endfunction

  // ****************************************
  // Captured straps
  // ****************************************
  psc_strap_t strap_nxt;

  // RXD0, RXD1 and CRS_DV give mode bits 0, 1 and 2.
  assign strap_nxt = {pad_s.rx_er, pad_s.crs_dv, pad_s.rxd[1],
                      pad_s.rxd[0]};

  always_ff @(posedge clk) begin
    if (hw_rst) begin
      strap_r <= `PSC_STRAP_RST;
    end else if (capture) begin
      strap_r <= strap_nxt;
    end
  end

  // ****************************************
  // Management address and mode field
  // ****************************************
  psc_mode_t mode_fld_r;

  always_ff @(posedge clk) begin
    if (hw_rst) begin
      station_address_field_r <= `PSC_ADDR_RST;
    end else if (capture) begin
      station_address_field_r <= {4'h0, strap_nxt.address_strap_bit};
    end else if (wr_smode) begin
      station_address_field_r <= bus_req.wdata[`PSC_SM_ADDR_MSB:0];
    end
  end

  always_ff @(posedge clk) begin
    if (hw_rst) begin
      mode_fld_r <= `PSC_MODE_10HD;
    end else if (capture) begin
      mode_fld_r <= strap_nxt.mode;
    end else if (wr_smode) begin
      mode_fld_r <= bus_req.wdata[`PSC_SM_MODE_MSB:`PSC_SM_MODE_LSB];
    end
  end

  // ****************************************
  // Control and advertisement bits
  // ****************************************
  always_ff @(posedge clk) begin
    if (hw_rst) begin
      ctrl_r <= `PSC_CTRL_RST;
    end else if (capture) begin
      ctrl_r <= ctrl_of(strap_nxt.mode, ctrl_r);
    end else if (wr_ctrl) begin
      ctrl_r.spd100 <= bus_req.wdata[`PSC_CTRL_SPD];
      ctrl_r.an_en <= bus_req.wdata[`PSC_CTRL_ANEN];
      ctrl_r.iso <= bus_req.wdata[`PSC_CTRL_ISO];
      ctrl_r.dpx <= bus_req.wdata[`PSC_CTRL_DPX];
    end
  end

  always_ff @(posedge clk) begin
    if (hw_rst) begin
      adv_r <= `PSC_ADV_RST;
    end else if (capture) begin
      adv_r <= adv_of(strap_nxt.mode, adv_r);
    end else if (wr_adv) begin
      adv_r <= bus_req.wdata[`PSC_ADV_MSB:`PSC_ADV_LSB];
    end
  end

  // ****************************************
  // Operating mode and soft reset
  // ****************************************
  // A soft reset re-derives the mode from the register field, never from
  // the pins, so power-down is left only once software has rewritten it.
  always_ff @(posedge clk) begin
    if (hw_rst) begin
      opmode_r <= '0;
    end else if (capture) begin
      opmode_r <= op_of(strap_nxt.mode);
    end else if (soft_req) begin
      opmode_r <= op_of(mode_fld_r);
    end
  end

  always_ff @(posedge clk) begin
    if (hw_rst) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= soft_req;
    end
  end

  // ****************************************
  // Frame address match and scrambler seed
  // ****************************************
  always_ff @(posedge clk) begin
    if (hw_rst) begin
      frm_match_r <= 1'b0;
    end else begin
      frm_match_r <= frm_valid && (frm_addr == station_address_field_r);
    end
  end

  // Each device seeds from its own address so that several scramblers
  // on one board do not run in step.
  always_ff @(posedge clk) begin
    if (hw_rst) begin
      scr_seed_r <= `PSC_ADDR_RST;
    end else begin
      scr_seed_r <= station_address_field_r;
    end
  end

  // ****************************************
  // Shared pins
  // ****************************************
  always_ff @(posedge clk) begin
    if (hw_rst) begin
      pad_oe_r <= '0;
      pad_o_r <= '0;
    end else begin
      pad_oe_r <= (capture || phase_r == PSC_PH_RUN) ? 4'hF : 4'h0;
      pad_o_r <= core_rx;
    end
  end

  // Pulls act through capture and the first run cycle; afterwards the pins are driven by us.
  always_ff @(posedge clk) begin
    if (hw_rst) begin
      pad_pu_r <= `PSC_PULL_LVL;
    end else if (phase_r == PSC_PH_RUN) begin
      pad_pu_r <= '0;
    end
  end

  // ****************************************
  // Register read
  // ****************************************
  psc_data_t rd_nxt;

  always_comb begin
    rd_nxt = '0;
    case (bus_req.addr)
      `PSC_IDX_CTRL: begin
        rd_nxt[`PSC_CTRL_SPD] = ctrl_r.spd100;
        rd_nxt[`PSC_CTRL_ANEN] = ctrl_r.an_en;
        rd_nxt[`PSC_CTRL_PDN] = opmode_r.power_down;
        rd_nxt[`PSC_CTRL_ISO] = ctrl_r.iso;
        rd_nxt[`PSC_CTRL_DPX] = ctrl_r.dpx;
      end
      `PSC_IDX_ADV: rd_nxt[`PSC_ADV_MSB:`PSC_ADV_LSB] = adv_r;
      `PSC_IDX_SMODE: begin
        rd_nxt[`PSC_SM_MODE_MSB:`PSC_SM_MODE_LSB] = mode_fld_r;
        rd_nxt[`PSC_SM_ADDR_MSB:0] = station_address_field_r;
      end
      `PSC_IDX_STRAP: rd_nxt[3:0] = strap_r;
      default: rd_nxt = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (hw_rst) begin
      bus_rdata_r <= '0;
    end else if (bus_req.re) begin
      bus_rdata_r <= rd_nxt;
    end else begin
      bus_rdata_r <= '0;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (hw_rst);

  property p_strap_capture;
    capture |=> strap_r.mode == {$past(pad_s.crs_dv), $past(pad_s.rxd)};
  endproperty
  a_strap_capture: assert property (p_strap_capture)
    else $error("mode strap not taken from receive pins");

  property p_addr_capture;
    capture |=> station_address_field_r == {4'h0, $past(pad_s.rx_er)};
  endproperty
  a_addr_capture: assert property (p_addr_capture)
    else $error("address strap not stored");

  property p_frame_match;
    frm_valid && frm_addr != station_address_field_r |=> !frm_match_r;
  endproperty
  a_frame_match: assert property (p_frame_match)
    else $error("frame with foreign address answered");

  property p_frame_hit;
    frm_valid && frm_addr == station_address_field_r |=> frm_match_r;
  endproperty
  a_frame_hit: assert property (p_frame_hit)
    else $error("frame with own address ignored");

  property p_seed;
    ##1 scr_seed_r == $past(station_address_field_r);
  endproperty
  a_seed: assert property (p_seed)
    else $error("scrambler seed differs from address");

  property p_pin_drive;
    capture ##1 phase_r == PSC_PH_RUN |-> pad_oe_r.rx_er ##1
      pad_o_r.rx_er == $past(core_rx.rx_er);
  endproperty
  a_pin_drive: assert property (p_pin_drive)
    else $error("receive error pin not driven after capture");

  property p_mode_100hd;
    capture && strap_nxt.mode == `PSC_MODE_100HD |=>
      ctrl_r == `PSC_CL_100HD && opmode_r.crs_tx;
  endproperty
  a_mode_100hd: assert property (p_mode_100hd)
    else $error("mode 010 loaded wrong control bits");

  property p_mode_rpt;
    capture && strap_nxt.mode == `PSC_MODE_RPT |=>
      adv_r == `PSC_AL_100HD && opmode_r.repeater && !opmode_r.crs_tx;
  endproperty
  a_mode_rpt: assert property (p_mode_rpt)
    else $error("repeater mode loaded wrong values");

  property p_mode_all;
    capture && strap_nxt.mode == `PSC_MODE_ALL |=> adv_r == `PSC_AL_ALL;
  endproperty
  a_mode_all: assert property (p_mode_all)
    else $error("mode 111 did not advertise all");

  property p_pdn_hold;
    opmode_r.power_down && !(soft_req && mode_fld_r != `PSC_MODE_PDN)
      |=> opmode_r.power_down;
  endproperty
  a_pdn_hold: assert property (p_pdn_hold)
    else $error("power-down left without soft reset");

  property p_soft_keep;
    soft_req |=> $stable(strap_r) && $stable(adv_r) &&
      $stable(station_address_field_r);
  endproperty
  a_soft_keep: assert property (p_soft_keep)
    else $error("soft reset disturbed register values");

  property p_strap_stable;
    phase_r == PSC_PH_RUN |=> $stable(strap_r);
  endproperty
  a_strap_stable: assert property (p_strap_stable)
    else $error("captured straps changed after capture");

  property p_pull;
    phase_r != PSC_PH_RUN |-> pad_pu_r == `PSC_PULL_LVL;
  endproperty
  a_pull: assert property (p_pull)
    else $error("strap pulls released before capture");

endmodule

`default_nettype wire

// *** psc_strap_board.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Board strap resistors on the shared pins
// ****************************************
// A fitted strap resistor beats the weak internal pull, but the device
// wins whenever it drives the pin.
module psc_strap_board (
  input wire psc_pkg::psc_rmii_rx_t strap_fit,
  input wire psc_pkg::psc_rmii_rx_t strap_val,
  input wire psc_pkg::psc_rmii_rx_t dev_o,
  input wire psc_pkg::psc_rmii_rx_t dev_oe,
  input wire psc_pkg::psc_rmii_rx_t dev_pu,
  output psc_pkg::psc_rmii_rx_t pad_lvl
);
  import psc_pkg::*;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (dev_oe[i]) begin
        pad_lvl[i] = dev_o[i];
      end else if (strap_fit[i]) begin
        pad_lvl[i] = strap_val[i];
      end else begin
        pad_lvl[i] = dev_pu[i];
      end
    end
  end
endmodule

`default_nettype wire

// *** psc_loader_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module psc_loader_tb;
  import psc_pkg::*;
  logic clk, sys_rst, pin_reset_n, frm_valid, frm_match_r, soft_rst_r;
  psc_rmii_rx_t pad_i, pad_o_r, pad_oe_r, pad_pu_r, core_rx, fit, sval;
  psc_bus_req_t bus_req;
  psc_data_t bus_rdata_r;
  psc_addr_t frm_addr, scr_seed_r, station_address_field_r;
  psc_ctrl_t ctrl_r;
  psc_adv_t adv_r;
  psc_opmode_t opmode_r;
  psc_strap_t strap_r;
  int num_errors, tests_run, cyc;
  logic [15:0] rd_v;

  psc_loader DUT (.clk(clk), .sys_rst(sys_rst), .pin_reset_n(pin_reset_n),
    .pad_i(pad_i), .pad_o_r(pad_o_r), .pad_oe_r(pad_oe_r),
    .pad_pu_r(pad_pu_r), .core_rx(core_rx), .bus_req(bus_req),
    .bus_rdata_r(bus_rdata_r), .frm_valid(frm_valid), .frm_addr(frm_addr),
    .frm_match_r(frm_match_r), .scr_seed_r(scr_seed_r),
    .station_address_field_r(station_address_field_r), .ctrl_r(ctrl_r),
    .adv_r(adv_r), .opmode_r(opmode_r), .soft_rst_r(soft_rst_r),
    .strap_r(strap_r));
  psc_strap_board board (.strap_fit(fit), .strap_val(sval), .dev_o(pad_o_r),
    .dev_oe(pad_oe_r), .dev_pu(pad_pu_r), .pad_lvl(pad_i));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    bus_req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus_req <= '0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    bus_req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk);
    bus_req <= '0;
    #1;
    d = bus_rdata_r;
  endtask

  // Straps are set on the same edge as the reset pin falls, so they are stable well
  // past the synchroniser delay when the pin rises again.
  task automatic pin_rst(input logic [3:0] f, input logic [2:0] m,
                         input logic a);
    @(posedge clk);
    fit <= f;
    sval <= {m, a};
    pin_reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk("pull_rst", 16'h000E, pad_pu_r);
    chk("oe_rst", 16'h0000, pad_oe_r);
    @(posedge clk);
    pin_reset_n <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_pull_default();
    chk("strap", 16'h0007, strap_r);
    chk("addr", 16'h0000, station_address_field_r);
    chk("ctrl", 16'h000D, ctrl_r);
    chk("adv", 16'h000F, adv_r);
    $display("test pull_default done");
  endtask

  task automatic t_modes();
    logic [3:0] ce [8] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'hC, 4'hC, 4'h0, 4'hD};
    logic [3:0] ae [8] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h4, 4'h4, 4'h0, 4'hF};
    logic [2:0] oe [8] = '{3'h0, 3'h0, 3'h2, 3'h0, 3'h2, 3'h4, 3'h1, 3'h0};
    for (int m = 0; m < 8; m++) begin
      pin_rst(4'hF, 3'(m), m[0]);
      chk("strap", {12'h000, m[0], 3'(m)}, strap_r);
      chk("ctrl", {12'h000, ce[m]}, ctrl_r);
      chk("adv", {12'h000, ae[m]}, adv_r);
      chk("opmode", {13'h0, oe[m]}, opmode_r);
      chk("addr", {11'h0, 4'h0, m[0]}, station_address_field_r);
      chk("seed", {11'h0, 4'h0, m[0]}, scr_seed_r);
      rd(5'h1F, rd_v);
      chk("rd_strap", {12'h000, m[0], 3'(m)}, rd_v);
      rd(5'h12, rd_v);
      chk("rd_smode", {8'h00, 3'(m), 4'h0, m[0]}, rd_v);
    end
    $display("test modes done");
  endtask

  task automatic t_power_down();
    pin_rst(4'hF, 3'h6, 1'b1);
    chk("opmode", 16'h0001, opmode_r);
    wr(5'h12, 16'h0061);
    wr(5'h00, 16'hA100);
    #1;
    chk("soft_rst", 16'h0001, soft_rst_r);
    chk("opmode", 16'h0000, opmode_r);
    chk("ctrl", 16'h0009, ctrl_r);
    chk("strap", 16'h000E, strap_r);
    chk("adv", 16'h0000, adv_r);
    @(posedge clk);
    #1;
    chk("soft_rst", 16'h0000, soft_rst_r);
    rd(5'h12, rd_v);
    chk("rd_smode", 16'h0061, rd_v);
    $display("test power_down done");
  endtask

  task automatic t_match();
    pin_rst(4'hF, 3'h3, 1'b1);
    @(posedge clk);
    frm_valid <= 1'b1;
    frm_addr <= 5'h01;
    @(posedge clk);
    frm_addr <= 5'h00;
    #1;
    chk("match", 16'h0001, frm_match_r);
    @(posedge clk);
    frm_valid <= 1'b0;
    #1;
    chk("match", 16'h0000, frm_match_r);
    wr(5'h12, 16'h0065);
    @(posedge clk);
    frm_valid <= 1'b1;
    frm_addr <= 5'h05;
    @(posedge clk);
    frm_valid <= 1'b0;
    #1;
    chk("match", 16'h0001, frm_match_r);
    chk("seed", 16'h0005, scr_seed_r);
    $display("test match done");
  endtask

  task automatic t_pins();
    chk("oe", 16'h000F, pad_oe_r);
    chk("pull_run", 16'h0000, pad_pu_r);
    @(posedge clk);
    core_rx <= 4'hA;
    sval <= 4'h0;
    @(posedge clk);
    #1;
    chk("pad_o", 16'h000A, pad_o_r);
    repeat (6) @(posedge clk);
    #1;
    chk("strap", 16'h000D, strap_r);
    wr(5'h04, 16'h01A0);
    rd(5'h04, rd_v);
    chk("rd_adv", 16'h01A0, rd_v);
    chk("adv", 16'h000D, adv_r);
    @(posedge clk);
    #1;
    chk("rdata_idle", 16'h0000, bus_rdata_r);
    rd(5'h03, rd_v);
    chk("rd_unmapped", 16'h0000, rd_v);
    $display("test pins done");
  endtask

  // ****************************************
  // Main sequence and hang guard
  // ****************************************
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      stop_test();
    end
  end

  initial begin
    num_errors = 0;
    tests_run = 0;
    cyc = 0;
    sys_rst = 1'b1;
    pin_reset_n = 1'b1;
    fit = 4'h0;
    sval = 4'h0;
    core_rx = 4'h0;
    bus_req = '0;
    frm_valid = 1'b0;
    frm_addr = 5'h00;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    t_pull_default();
    t_modes();
    t_power_down();
    t_match();
    pin_rst(4'hF, 3'h5, 1'b1);
    t_pins();
    stop_test();
  end
endmodule

`default_nettype wire
